// File: core/mds_dac_core.sv
// What this block does
// - Frame is 24 bits: address byte then 16-bit data word.
// - MSB captured on first rising serial clock edge, rest on following edges.
// - Bits shift regardless of strobe; strobe rising edge always transfers frame.
// - Shift register clears to zero at power-on and system reset; soft reset clears it on the third edge of the next frame.
// - Serial clock up to 31 MHz; host stays within it.
// - Code is unsigned; output is reference times gain times code over 65536, with mid-code subtracted on bipolar ranges.
// - Gain follows range: x1 for 0-5V, x2 for 0-10V and +-5V, x4 for +-10V.
module mds_dac_core
  import mds_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SCLK,
  input wire logic I_SDI,
  input wire logic I_LATCH,
  output logic O_SDO,
  output logic [mds_pkg::DATA_W-1:0] O_CODE,
  output logic [1:0] O_GAIN_SHIFT,
  output logic O_BIPOLAR,
  output logic O_OUT_EN,
  output logic signed [18:0] O_LEVEL
);
  import mds_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latch_prev;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] code;
    logic [DATA_W-1:0] gain_trim;
    logic [DATA_W-1:0] zero_trim;
    logic [ADDR_W-1:0] rb_sel;
    logic [FRAME_W-1:0] rb_word;
    logic bad_addr;
    logic soft_rst;
    logic clr_tgl;
    logic [DATA_W-1:0] code_out;
    logic [1:0] gain_sh;
    logic bipolar;
    logic out_en;
    logic signed [18:0] level;
  } mds_core_st_t;

  localparam mds_core_st_t ST_RST = '{
    latch_prev: 1'b0,
    ctrl: CTRL_RST,
    cfg: CFG_RST,
    code: CODE_RST,
    gain_trim: GAIN_TRIM_RST,
    zero_trim: ZERO_TRIM_RST,
    rb_sel: ADDR_NOP,
    rb_word: SHIFT_RST,
    bad_addr: 1'b0,
    soft_rst: 1'b0,
    clr_tgl: 1'b0,
    code_out: CODE_RST,
    gain_sh: GAIN_SH_X1,
    bipolar: 1'b0,
    out_en: 1'b0,
    level: 19'sh00000
  };

  mds_core_st_t q;
  mds_core_st_t d;
  logic latch_s;
  logic [FRAME_W-1:0] frame_raw;
  mds_frame_t frame_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] a, input mds_core_st_t s);
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      ADDR_CODE: v = s.code;
      ADDR_CTRL: v = s.ctrl;
      ADDR_CFG: v = s.cfg;
      ADDR_GAIN_TRIM: v = s.gain_trim;
      ADDR_ZERO_TRIM: v = s.zero_trim;
      ADDR_STATUS: begin
        v[STAT_OUT_ON_BIT] = s.out_en;
        v[STAT_BAD_ADDR_BIT] = s.bad_addr;
      end
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic [1:0] range_gain(input logic [2:0] r);
    logic [1:0] g;
    g = GAIN_SH_X1;
    case (r)
      RANGE_0_5V: g = GAIN_SH_X1;
      RANGE_0_10V, RANGE_PM5V: g = GAIN_SH_X2;
      RANGE_PM10V: g = GAIN_SH_X4;
      default: g = GAIN_SH_X1;
    endcase
    return g;
  endfunction

  // Gain trim is a fraction (trim+1)/65536, zero trim a signed offset; result clamps to code range
  function automatic logic [DATA_W-1:0] apply_trim(input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] g,
                                                    input logic [DATA_W-1:0] z);
    logic [32:0] prod;
    logic signed [18:0] sum;
    logic [DATA_W-1:0] r;
    prod = {17'h00000, c} * ({17'h00000, g} + 33'h000000001);
    sum = $signed({2'b00, prod[32:16]}) + $signed({{3{z[15]}}, z});
    if (sum < 19'sh00000) begin
      r = 16'h0000;
    end else if (sum > 19'sh0ffff) begin
      r = 16'hffff;
    end else begin
      r = sum[15:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Serial link and crossings
  // ----------------------------------------------------------------
  mds_serial_port u_port (
    .i_sclk(I_SCLK),
    .i_sys_rst(I_SYS_RST),
    .i_clr_tgl(q.clr_tgl),
    .i_sdi(I_SDI),
    .i_rb_word(q.rb_word),
    .o_frame(frame_raw),
    .o_sdo(O_SDO)
  );

  // The frame is frozen before the strobe rises, so it and the strobe see equal delay
  mds_sync #(.W(1)) u_latch_sync (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_async(I_LATCH), .o_sync(latch_s));
  mds_sync #(.W(FRAME_W)) u_frame_sync (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_async(frame_raw),
    .o_sync(frame_s));

  // ----------------------------------------------------------------
  // Register writes on the strobe edge
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.soft_rst = 1'b0;
    d.latch_prev = latch_s;
    if (latch_s && !q.latch_prev) begin
      case (frame_s.addr)
        ADDR_NOP: d.rb_sel = q.rb_sel;
        ADDR_CODE: d.code = frame_s.data;
        ADDR_CTRL: d.ctrl = frame_s.data;
        ADDR_CFG: d.cfg = frame_s.data;
        ADDR_GAIN_TRIM: d.gain_trim = frame_s.data;
        ADDR_ZERO_TRIM: d.zero_trim = frame_s.data;
        ADDR_READBACK: begin
          d.rb_sel = frame_s.data[ADDR_W-1:0];
          if (frame_s.data[ADDR_W-1:0] == ADDR_STATUS) begin
            d.bad_addr = 1'b0;
          end
        end
        ADDR_SOFT_RST: d.soft_rst = frame_s.data[SOFT_RST_BIT];
        default: d.bad_addr = 1'b1;
      endcase
    end

    // ----------------------------------------------------------------
    // Output path
    // ----------------------------------------------------------------
    d.rb_word = {q.rb_sel, reg_value(q.rb_sel, q)};
    d.out_en = q.ctrl[CTRL_OUT_EN_BIT];
    d.gain_sh = range_gain(q.ctrl[CTRL_RANGE_LSB +: 3]);
    d.bipolar = (q.ctrl[CTRL_RANGE_LSB +: 3] == RANGE_PM5V) || (q.ctrl[CTRL_RANGE_LSB +: 3] == RANGE_PM10V);
    if (!q.out_en) begin
      d.code_out = CODE_RST;
    end else if (q.cfg[CFG_CAL_EN_BIT]) begin
      d.code_out = apply_trim(q.code, q.gain_trim, q.zero_trim);
    end else begin
      d.code_out = q.code;
    end
    // Level in units of reference/65536, bipolar ranges centred on mid-code
    d.level = ($signed({3'b000, q.code_out}) - (q.bipolar ? BIPOLAR_MID : 19'sh00000)) <<< q.gain_sh;

    // A soft reset restores every register but the strobe history and clear toggle, and also clears the serial shift register
    if (q.soft_rst) begin
      d = ST_RST;
      // Keep the strobe history so the still-high strobe is not seen as a fresh edge
      d.latch_prev = latch_s;
      d.clr_tgl = ~q.clr_tgl;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign O_CODE = q.code_out;
  assign O_GAIN_SHIFT = q.gain_sh;
  assign O_BIPOLAR = q.bipolar;
  assign O_OUT_EN = q.out_en;
  assign O_LEVEL = q.level;

  // Serial clock may run up to SCLK_MAX_HZ; the shifter lives wholly on it.
endmodule // mds_dac_core

// File: core/mds_pkg.sv
package mds_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mds_frame_t;

  // ----------------------------------------------------------------
  // Register addresses carried in the address byte
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_NOP = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CODE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_READBACK = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RST = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_TRIM = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_OUT_EN_BIT = 12;
  localparam int CFG_CAL_EN_BIT = 5;
  localparam int SOFT_RST_BIT = 0;
  localparam int STAT_OUT_ON_BIT = 0;
  localparam int STAT_BAD_ADDR_BIT = 1;

  // Output range codes in the control register
  localparam logic [2:0] RANGE_0_5V = 3'h0;
  localparam logic [2:0] RANGE_0_10V = 3'h1;
  localparam logic [2:0] RANGE_PM5V = 3'h2;
  localparam logic [2:0] RANGE_PM10V = 3'h3;

  // Gain expressed as a left shift: x1, x2, x4
  localparam logic [1:0] GAIN_SH_X1 = 2'h0;
  localparam logic [1:0] GAIN_SH_X2 = 2'h1;
  localparam logic [1:0] GAIN_SH_X4 = 2'h2;
  localparam logic signed [18:0] BIPOLAR_MID = 19'sh08000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [FRAME_W-1:0] SHIFT_RST = 24'h000000;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CFG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] GAIN_TRIM_RST = 16'hffff;
  localparam logic [DATA_W-1:0] ZERO_TRIM_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SCLK_MAX_HZ = 31_000_000;

endpackage

// File: core/mds_sync.sv
module mds_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mds_sync_st_t;

  mds_sync_st_t q;
  mds_sync_st_t d;

  // First stage feeds only the second stage
  always_comb begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule // mds_sync

// File: core/mds_serial_port.sv
module mds_serial_port
  import mds_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_sys_rst,
  input wire logic i_clr_tgl,
  input wire logic i_sdi,
  input wire logic [mds_pkg::FRAME_W-1:0] i_rb_word,
  output logic [mds_pkg::FRAME_W-1:0] o_frame,
  output logic o_sdo
);
  typedef struct packed {
    logic [FRAME_W-1:0] shift;
    logic [FRAME_W-1:0] out;
    logic [4:0] cnt;
    logic clr_ack;
  } mds_ser_st_t;

  mds_ser_st_t q;
  mds_ser_st_t d;
  logic rst_s;
  logic clr_s;
  logic [FRAME_W-1:0] rb_s;

  // ----------------------------------------------------------------
  // Crossings into the serial clock domain
  // ----------------------------------------------------------------
  mds_sync #(.W(1)) u_rst_sync (.i_clk(i_sclk), .i_rst(1'b0), .i_async(i_sys_rst), .o_sync(rst_s));
  mds_sync #(.W(1)) u_clr_sync (.i_clk(i_sclk), .i_rst(rst_s), .i_async(i_clr_tgl), .o_sync(clr_s));
  // Readback word only moves after a strobe, while the serial clock must stay idle, so it is
  // quasi-static here; a synchroniser would go stale because this clock stops between frames
  assign rb_s = i_rb_word;

  // ----------------------------------------------------------------
  // Shift logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.shift = {q.shift[FRAME_W-2:0], i_sdi};
    if (clr_s != q.clr_ack) begin
      // Clearing and capturing on the same edge keeps the bit shifted in on that edge, the third bit of the next frame
      d.shift = {SHIFT_RST[FRAME_W-1:1], i_sdi};
      d.clr_ack = clr_s;
    end
    d.cnt = (q.cnt == 5'(FRAME_W - 1)) ? 5'h00 : q.cnt + 5'h01;
    d.out = (q.cnt == 5'h00) ? rb_s : {q.out[FRAME_W-2:0], 1'b0};
  end

  always_ff @(posedge i_sclk) begin
    if (rst_s) begin
      q <= '{shift: SHIFT_RST, out: '0, cnt: 5'h00, clr_ack: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_frame = q.shift;
  assign o_sdo = q.out[FRAME_W-1];
endmodule // mds_serial_port

// File: test/mds_dac_monitor.sv
module mds_dac_monitor
  import mds_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_LATCH,
  input wire logic [DATA_W-1:0] O_CODE,
  input wire logic [1:0] O_GAIN_SHIFT,
  input wire logic O_BIPOLAR,
  input wire logic O_OUT_EN,
  input wire logic signed [18:0] O_LEVEL
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ------
  // Cycles since the strobe rose
  // ------
  logic lat_q;
  logic [3:0] since_q;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      lat_q <= 1'b0;
      since_q <= 4'hf;
    end else begin
      lat_q <= I_LATCH;
      since_q <= (I_LATCH && !lat_q) ? 4'h0 : (since_q == 4'hf) ? since_q : since_q + 4'h1;
    end
  end
  sequence s_steady;
    $stable(O_CODE) && $stable(O_GAIN_SHIFT) && $stable(O_BIPOLAR);
  endsequence
  sequence s_moved;
    $changed(O_CODE) || $changed(O_GAIN_SHIFT) || $changed(O_OUT_EN);
  endsequence
  a_reset_clears: assert property ($fell(I_SYS_RST) |-> O_CODE == 16'h0000 && !O_OUT_EN && O_LEVEL == 19'sh00000)
    else $error("outputs not cleared by reset");
  a_gain_legal: assert property (O_GAIN_SHIFT != 2'h3)
    else $error("gain shift out of range");
  a_wide_bipolar: assert property (O_GAIN_SHIFT == GAIN_SH_X4 |-> O_BIPOLAR)
    else $error("x4 gain on unipolar range");
  a_bipolar_gain: assert property (O_BIPOLAR |-> O_GAIN_SHIFT != GAIN_SH_X1)
    else $error("bipolar range with x1 gain");
  a_level_formula: assert property (s_steady [*3] |->
    O_LEVEL == (($signed({3'b000, O_CODE}) - (O_BIPOLAR ? BIPOLAR_MID : 19'sh00000)) <<< O_GAIN_SHIFT))
    else $error("level does not match code and gain");
  a_code_on_strobe: assert property (s_moved |-> since_q inside {[4'h1:4'h8]})
    else $error("output changed away from a strobe");
  a_level_on_strobe: assert property ($changed(O_LEVEL) |-> since_q inside {[4'h1:4'h9]})
    else $error("level changed away from a strobe");
  a_off_zero: assert property (!O_OUT_EN [*2] |-> O_CODE == 16'h0000)
    else $error("code not zero while disabled");
endmodule // mds_dac_monitor

bind mds_dac_core mds_dac_monitor i_mds_dac_monitor (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_LATCH(I_LATCH),
  .O_CODE(O_CODE), .O_GAIN_SHIFT(O_GAIN_SHIFT), .O_BIPOLAR(O_BIPOLAR), .O_OUT_EN(O_OUT_EN), .O_LEVEL(O_LEVEL));

// File: test/mds_host_model.sv
module mds_host_model #(
  parameter int SETTLE_CYC = 4,
  parameter int SAMPLE_CYC = 6000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_hold,
  input wire logic [23:0] i_word,
  input wire logic i_sdo,
  output logic o_busy,
  output logic [23:0] o_rb,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  // Far-side multiplexer controls, kept to follow the slot order
  logic mux_connect_enable;
  logic [2:0] mux_channel_select;
  logic [2:0] slot_q;
  int tail;
  initial begin
    mux_connect_enable = 1'b0;
    mux_channel_select = 3'h0;
    slot_q = 3'h0;
    tail = 0;
    o_busy = 1'b0;
    o_rb = 24'h000000;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_latch = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_rst) begin
        // Serial side only sees reset on its own clock edges
        tail = 1;
        #5 o_sclk = 1'b1;
        #35 o_sclk = 1'b0;
      end else if (tail > 0) begin
        // One more edge drains the serial reset synchroniser before any frame bit
        tail = tail - 1;
        #5 o_sclk = 1'b1;
        #35 o_sclk = 1'b0;
      end else if (i_start) begin
        o_busy <= 1'b1;
        mux_connect_enable <= 1'b0;
        if (i_hold) begin
          o_latch <= 1'b1;
          repeat (5) @(posedge i_clk);
        end
        #13;
        for (int i = 23; i >= 0; i--) begin
          o_sdi = i_word[i];
          #40 o_sclk = 1'b1;
          #40 o_rb = {o_rb[22:0], i_sdo};
          o_sclk = 1'b0;
        end
        // Released line shows the inverse, never a stale bit
        o_sdi = ~o_sdi;
        o_latch <= 1'b0;
        mux_channel_select <= slot_q;
        repeat (2) @(posedge i_clk);
        o_latch <= 1'b1;
        repeat (5) @(posedge i_clk);
        o_latch <= 1'b0;
        repeat (SETTLE_CYC) @(posedge i_clk);
        mux_connect_enable <= 1'b1;
        repeat (SAMPLE_CYC) @(posedge i_clk);
        mux_connect_enable <= 1'b0;
        slot_q <= slot_q + 3'h1;
        o_busy <= 1'b0;
      end
    end
  end
endmodule // mds_host_model

// File: test/test_mds_dac_core.sv
module test_mds_dac_core
  import mds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic hold = 1'b0;
  logic [23:0] word = 24'h000000;
  logic busy, sclk, sdi, latch, sdo, bip, oen;
  logic [23:0] rb;
  logic [15:0] code_o, c;
  logic [1:0] gsh;
  logic signed [18:0] lvl;
  logic [31:0] seed = 32'h2ecb9133;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  mds_dac_core i_mds_dac_core (.I_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk), .I_SDI(sdi), .I_LATCH(latch),
    .O_SDO(sdo), .O_CODE(code_o), .O_GAIN_SHIFT(gsh), .O_BIPOLAR(bip), .O_OUT_EN(oen), .O_LEVEL(lvl));
  // Sample phase shortened so the run stays within its cycle budget
  mds_host_model #(.SAMPLE_CYC(2)) i_mds_host_model (.i_clk(clk), .i_rst(rst), .i_start(start), .i_hold(hold),
    .i_word(word),
    .i_sdo(sdo), .o_busy(busy), .o_rb(rb), .o_sclk(sclk), .o_sdi(sdi), .o_latch(latch));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic signed [18:0] exp_lvl(logic [15:0] v, logic [1:0] r);
    logic signed [18:0] b;
    b = $signed({3'b000, v}) - (r[1] ? BIPOLAR_MID : 19'sh00000);
    return b <<< ((r == 2'h3) ? 2 : (r == 2'h0) ? 0 : 1);
  endfunction
  task automatic send(input logic [7:0] a, input logic [15:0] d, input logic h);
    int n;
    n = 0;
    word <= {a, d};
    hold <= h;
    start <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b1 && n < 300);
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 300);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("code", 16'h0000, code_o)
    `CHK("level", 19'sh00000, lvl)
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 16'h0000 : (i == 3) ? 16'hffff : seed[15:0];
      send(ADDR_CTRL, {13'h0200, 1'b0, i[1:0]}, 1'b0);
      send(ADDR_CODE, c, i[2]);
      `CHK("gain", (i[1:0] == 2'h3) ? GAIN_SH_X4 : (i[1:0] == 2'h0) ? GAIN_SH_X1 : GAIN_SH_X2, gsh)
      `CHK("bipolar", i[1], bip)
      `CHK("code", c, code_o)
      `CHK("level", exp_lvl(c, i[1:0]), lvl)
    end
    $display("range test done");
    send(ADDR_READBACK, {8'h00, ADDR_CODE}, 1'b0);
    send(ADDR_NOP, 16'h0000, 1'b0);
    `CHK("readback", {ADDR_CODE, c}, rb)
    send(ADDR_READBACK, {8'h00, ADDR_STATUS}, 1'b0);
    send(8'h3c, seed[31:16], 1'b0);
    send(ADDR_CTRL, 16'h0000, 1'b0);
    `CHK("disabled code", 16'h0000, code_o)
    send(ADDR_NOP, 16'h0000, 1'b0);
    `CHK("status", {ADDR_STATUS, 16'h0002}, rb)
    $display("readback test done");
    send(ADDR_CTRL, 16'h1002, 1'b0);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("bipolar", 1'b0, bip)
    `CHK("enable", 1'b0, oen)
    send(ADDR_CTRL, 16'h1001, 1'b0);
    send(ADDR_CODE, 16'h8001, 1'b0);
    `CHK("level", exp_lvl(16'h8001, 2'h1), lvl)
    send(ADDR_CFG, 16'h0020, 1'b0);
    send(ADDR_ZERO_TRIM, 16'h0010, 1'b0);
    `CHK("trimmed code", 16'h8011, code_o)
    send(ADDR_SOFT_RST, 16'h0001, 1'b0);
    `CHK("soft reset enable", 1'b0, oen)
    `CHK("soft reset code", 16'h0000, code_o)
    send(ADDR_CTRL, 16'h1000, 1'b0);
    send(ADDR_CODE, 16'h1234, 1'b0);
    `CHK("code after soft reset", 16'h1234, code_o)
    $display("second reset test done");
    end_sim();
  end
endmodule // test_mds_dac_core
